// file: hdl/freerun_capture_overflow.sv
`timescale 1ns/1ps
`include "freerun_capture_consts.svh"
// Behaviour
// RULE_01 - two capture registers capture independently
// RULE_02 - capture loads count, pulses capture irq
// RULE_03 - one overflow flag shared by both
// RULE_04 - counter wraps every 10000H counts
// RULE_05 - overflow flag sticky, never counts wraps
// RULE_06 - software counts wraps for long intervals
// RULE_07 - clear by bit clear or option write
// RULE_08 - zero write beats coincident overflow set
// RULE_09 - overflow set beats coincident bit clear
// RULE_10 - software reads flag before bit clear
// RULE_11 - after FFFFH: irq, reload 0000H, set flag
module freerun_capture_overflow
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic countEnable,
   input wire logic capture_input_a,
   input wire logic capture_input_b,
   input wire freerun_capture_pkg::edge_sel_t edgeSelA,
   input wire freerun_capture_pkg::edge_sel_t edgeSelB,
   input wire freerun_capture_pkg::flag_ctl_t flagCtl,
   output logic [`CNT_WIDTH-1:0] counterValue,
   output logic [`CNT_WIDTH-1:0] capture_value_reg_a,
   output logic [`CNT_WIDTH-1:0] capture_value_reg_b,
   output logic counter_wrap_flag,
   output freerun_capture_pkg::irq_t irqOut
);
   logic rstMeta_q;
   logic rstSync_q;
   logic [`CNT_WIDTH-1:0] count_q;
   logic [`CNT_WIDTH-1:0] capA_q;
   logic [`CNT_WIDTH-1:0] capB_q;
   logic flag_q;
   logic wrapSet;
   logic hitA;
   logic hitB;
   logic clearPending_q;
   logic zeroClear;
   logic clearWrite;
   freerun_capture_pkg::irq_t irq_q;
   freerun_capture_pkg::clear_state_t clearState_q;

   // ----------------------------------------
   // control decoding
   // ----------------------------------------
   function automatic logic isZeroClear(freerun_capture_pkg::flag_ctl_t ctl);
      isZeroClear = ctl.zeroWrite && !ctl.optionData[`FLAG_BIT];
   endfunction : isZeroClear
   function automatic logic isClearWrite(freerun_capture_pkg::clear_state_t st, logic pending);
      isClearWrite = (st == freerun_capture_pkg::CLEAR_WRITE) && !pending;
   endfunction : isClearWrite

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end
      else
      begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end

   // ----------------------------------------
   // capture pins
   // ----------------------------------------
   capture_edge_detect edgeA
   (
      .clk(clk),
      .rstSyncB(rstSync_q),
      .pinIn(capture_input_a),
      .edgeSel(edgeSelA),
      .edgeHit(hitA)
   );
   capture_edge_detect edgeB
   (
      .clk(clk),
      .rstSyncB(rstSync_q),
      .pinIn(capture_input_b),
      .edgeSel(edgeSelB),
      .edgeHit(hitB)
   );

   // ----------------------------------------
   // free running counter
   // ----------------------------------------
   assign wrapSet = countEnable && (count_q == `CNT_MAX);
   always_ff @(posedge clk or negedge rstSync_q)
   begin
      if (!rstSync_q)
      begin
         count_q <= `CNT_ZERO;
      end
      else if (!countEnable)
      begin
         count_q <= `CNT_ZERO;
      end
      else if (wrapSet)
      begin
         count_q <= `CNT_ZERO; // RULE_11 RULE_04
      end
      else
      begin
         count_q <= count_q + `CNT_ONE;
      end
   end

   // ----------------------------------------
   // capture registers
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstSync_q)
   begin
      if (!rstSync_q)
         capA_q <= `CNT_ZERO;
      else if (countEnable && hitA)
      begin
         capA_q <= count_q; // RULE_01 RULE_02
      end
   end
   always_ff @(posedge clk or negedge rstSync_q)
   begin
      if (!rstSync_q)
         capB_q <= `CNT_ZERO;
      else if (countEnable && hitB)
      begin
         capB_q <= count_q; // RULE_01 RULE_02
      end
   end

   // ----------------------------------------
   // interrupt pulses
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstSync_q)
   begin
      if (!rstSync_q)
         irq_q <= '0;
      else
      begin
         irq_q.wrapIrq <= wrapSet; // RULE_11
         irq_q.captureIrqA <= countEnable && hitA; // RULE_02
         irq_q.captureIrqB <= countEnable && hitB; // RULE_02
      end
   end

   // ----------------------------------------
   // bit clear sequence: read then write
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstSync_q)
   begin
      if (!rstSync_q)
         clearState_q <= freerun_capture_pkg::CLEAR_IDLE;
      else
      begin
         unique case (clearState_q)
            freerun_capture_pkg::CLEAR_IDLE:
               if (flagCtl.bitClear)
                  clearState_q <= freerun_capture_pkg::CLEAR_READ;
            freerun_capture_pkg::CLEAR_READ:
               clearState_q <= freerun_capture_pkg::CLEAR_WRITE;
            freerun_capture_pkg::CLEAR_WRITE:
               clearState_q <= freerun_capture_pkg::CLEAR_IDLE;
            default:
               clearState_q <= freerun_capture_pkg::CLEAR_IDLE;
         endcase
      end
   end
   // overflow seen during the read-modify-write keeps the flag
   always_ff @(posedge clk or negedge rstSync_q)
   begin
      if (!rstSync_q)
      begin
         clearPending_q <= 1'b0;
      end
      else if (clearState_q == freerun_capture_pkg::CLEAR_IDLE)
      begin
         clearPending_q <= 1'b0;
      end
      else if (wrapSet)
      begin
         clearPending_q <= 1'b1; // RULE_09
      end
   end

   // ----------------------------------------
   // shared overflow flag
   // ----------------------------------------
   assign zeroClear = isZeroClear(flagCtl);
   assign clearWrite = isClearWrite(clearState_q, clearPending_q);
   always_ff @(posedge clk or negedge rstSync_q)
   begin
      if (!rstSync_q)
      begin
         flag_q <= 1'b0;
      end
      else if (zeroClear)
      begin
         flag_q <= 1'b0; // RULE_07 RULE_08
      end
      else if (wrapSet)
      begin
         flag_q <= 1'b1; // RULE_03 RULE_05 RULE_09
      end
      else if (clearWrite)
      begin
         flag_q <= 1'b0; // RULE_07 RULE_09
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign counterValue = count_q;
   assign capture_value_reg_a = capA_q;
   assign capture_value_reg_b = capB_q;
   assign counter_wrap_flag = flag_q;
   assign irqOut = irq_q;
endmodule : freerun_capture_overflow

// file: hdl/freerun_capture_consts.svh
`ifndef FREERUN_CAPTURE_CONSTS_SVH
`define FREERUN_CAPTURE_CONSTS_SVH
`define CNT_WIDTH 16
`define CNT_ZERO 16'h0000
`define CNT_MAX 16'hffff
`define CNT_ONE 16'h0001
`define FLAG_BIT 0
`define EDGE_NONE 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3
`endif

// file: hdl/freerun_capture_pkg.sv
package freerun_capture_pkg;
   typedef logic [1:0] edge_sel_t;
   typedef struct packed
   {
      logic wrapIrq;
      logic captureIrqA;
      logic captureIrqB;
   } irq_t;
   typedef struct packed
   {
      logic zeroWrite;
      logic [7:0] optionData;
      logic bitClear;
   } flag_ctl_t;
   typedef enum logic [2:0]
   {
      CLEAR_IDLE = 3'h1,
      CLEAR_READ = 3'h2,
      CLEAR_WRITE = 3'h4
   } clear_state_t;
endpackage : freerun_capture_pkg

// file: hdl/capture_edge_detect.sv
`timescale 1ns/1ps
`include "freerun_capture_consts.svh"
module capture_edge_detect
(
   input wire logic clk,
   input wire logic rstSyncB,
   input wire logic pinIn,
   input wire freerun_capture_pkg::edge_sel_t edgeSel,
   output logic edgeHit
);
   logic sync1_q;
   logic sync2_q;
   logic prev_q;
   // ----------------------------------------
   // pin synchroniser and edge select
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstSyncB)
   begin
      if (!rstSyncB)
      begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q <= 1'b0;
      end
      else
      begin
         sync1_q <= pinIn;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end
   always_comb
   begin
      unique case (edgeSel)
         `EDGE_RISE: edgeHit = sync2_q & ~prev_q;
         `EDGE_FALL: edgeHit = ~sync2_q & prev_q;
         `EDGE_BOTH: edgeHit = sync2_q ^ prev_q;
         default: edgeHit = 1'b0;
      endcase
   end
endmodule : capture_edge_detect

// file: tb/freerun_capture_checker.sv
`timescale 1ns/1ps
module freerun_capture_checker
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic countEnable,
   input wire freerun_capture_pkg::flag_ctl_t flagCtl,
   input wire logic [15:0] counterValue,
   input wire logic [15:0] capture_value_reg_a,
   input wire logic [15:0] capture_value_reg_b,
   input wire logic counter_wrap_flag,
   input wire freerun_capture_pkg::irq_t irqOut
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire logic zeroClr = flagCtl.zeroWrite && !flagCtl.optionData[0];
   wire logic atMax = countEnable && counterValue == 16'hffff;
   sequence sClearMeetsWrap;
      flagCtl.bitClear ##[1:2] (atMax && !zeroClr);
   endsequence
   a_wrap_sets_flag: assert property (atMax && !zeroClr |=>
      counterValue == 16'h0000 && counter_wrap_flag && irqOut.wrapIrq) else $error("wrap");
   a_zero_write_wins: assert property (zeroClr |=> !counter_wrap_flag) else $error("zero write");
   a_set_beats_clear: assert property (sClearMeetsWrap |-> ##3 counter_wrap_flag) else $error("set lost");
   a_count_step: assert property (countEnable && !atMax |=>
      counterValue == $past(counterValue) + 16'h0001) else $error("count");
   a_wrap_irq_cause: assert property (irqOut.wrapIrq |-> $past(atMax)) else $error("wrap irq");
   a_flag_sticky: assert property ($fell(counter_wrap_flag) |->
      $past(flagCtl.zeroWrite) || $past(flagCtl.bitClear, 3)) else $error("flag");
   a_capture_a_irq: assert property ($changed(capture_value_reg_a) |-> irqOut.captureIrqA) else $error("a");
   a_capture_b_irq: assert property ($changed(capture_value_reg_b) |-> irqOut.captureIrqB) else $error("b");
endmodule : freerun_capture_checker

// file: tb/capture_pin_model.sv
`timescale 1ns/1ps
module capture_pin_model
(
   input wire logic clk,
   output logic pinA,
   output logic pinB
);
   initial pinA = 1'b0;
   initial pinB = 1'b0;
   task automatic pulse(logic sel, int width);
      repeat (2)
      begin
         @(negedge clk);
         if (sel)
            pinB = ~pinB;
         else
            pinA = ~pinA;
         repeat (width - 1) @(negedge clk);
      end
   endtask : pulse
endmodule : capture_pin_model

// file: tb/freerun_capture_overflow_tb.sv
`timescale 1ns/1ps
module freerun_capture_overflow_tb;
   logic clk = 1'b0, rst_b = 1'b0, countEnable = 1'b0, pinA, pinB, flag;
   logic [15:0] count, capA, capB, firstA;
   freerun_capture_pkg::edge_sel_t edgeSelB = 2'h0;
   freerun_capture_pkg::flag_ctl_t flagCtl = 10'h000;
   freerun_capture_pkg::irq_t irqOut;
   int fail_count = 0, tests_run = 0, nB = 0, nW = 0;
   freerun_capture_overflow freerun_capture_overflow_inst (.clk(clk), .rst_b(rst_b), .countEnable(countEnable),
      .capture_input_a(pinA), .capture_input_b(pinB), .edgeSelA(2'h3), .edgeSelB(edgeSelB), .flagCtl(flagCtl),
      .counterValue(count), .capture_value_reg_a(capA), .capture_value_reg_b(capB),
      .counter_wrap_flag(flag), .irqOut(irqOut));
   capture_pin_model capture_pin_model_inst (.clk(clk), .pinA(pinA), .pinB(pinB));
   initial forever #20 clk = ~clk;
   always @(negedge clk) nB += irqOut.captureIrqB;
   always @(negedge clk) nW += irqOut.wrapIrq;
   task close_out;
      if (fail_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : close_out
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("CHECK FAILED %s exp %h got %h", what, exp, got);
         fail_count++;
      end
   endtask : chk
   task automatic waitUntil(logic sel, logic [15:0] v);
      for (int i = 0; i < 70000; i++)
      begin
         @(negedge clk);
         if (sel ? irqOut.captureIrqA === 1'b1 : count === v)
            return;
      end
      fail_count++;
      close_out();
   endtask : waitUntil
   initial
   begin
      repeat (6) @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      countEnable = 1'b1;
      for (int m = 0; m < 4; m++)
      begin
         edgeSelB = m[1:0];
         nB = 0;
         capture_pin_model_inst.pulse(1'b1, 20);
         repeat (8) @(negedge clk);
         chk("irqB", (m == 0) ? 16'h0000 : (m == 3) ? 16'h0002 : 16'h0001, 16'(nB));
      end
      chk("capA", 16'h0000, capA);
      waitUntil(1'b0, 16'hffe0);
      fork
         capture_pin_model_inst.pulse(1'b0, 40);
         begin
            waitUntil(1'b1, 16'h0000);
            firstA = capA;
            nW = 0;
            waitUntil(1'b1, 16'h0000);
            chk("width", 16'h0028, capA - firstA);
            chk("wraps", 16'h0001, 16'(nW));
         end
         begin
            waitUntil(1'b0, 16'hfffe);
            flagCtl.bitClear = 1'b1;
            @(negedge clk) flagCtl.bitClear = 1'b0;
         end
      join
      chk("flag set", 16'h0001, {15'h0000, flag});
      flagCtl.optionData = 8'h01;
      flagCtl.zeroWrite = 1'b1;
      @(negedge clk) flagCtl.zeroWrite = 1'b0;
      repeat (2) @(negedge clk);
      flagCtl.optionData = 8'h00;
      chk("flag kept", 16'h0001, {15'h0000, flag});
      if (flag === 1'b1)
         flagCtl.bitClear = 1'b1;
      @(negedge clk) flagCtl.bitClear = 1'b0;
      repeat (4) @(negedge clk);
      chk("flag clr", 16'h0000, {15'h0000, flag});
      flagCtl.zeroWrite = 1'b1;
      @(negedge clk) flagCtl.zeroWrite = 1'b0;
      repeat (2) @(negedge clk);
      chk("flag zero", 16'h0000, {15'h0000, flag});
      close_out();
   end
endmodule : freerun_capture_overflow_tb
bind freerun_capture_overflow freerun_capture_checker freerun_capture_checker_inst (.clk(clk), .rst_b(rst_b),
   .countEnable(countEnable), .flagCtl(flagCtl), .counterValue(counterValue),
   .capture_value_reg_a(capture_value_reg_a), .capture_value_reg_b(capture_value_reg_b),
   .counter_wrap_flag(counter_wrap_flag), .irqOut(irqOut));
